// >>> src/vline_pkg.sv
// Purpose: shared constants and types for the vertical line defect corrector
// Assumes: 40 MHz hclk, AHB-Lite register access, 12-bit raw pixels
// Notes: register offsets are byte addresses of aligned 32-bit words
package vline_pkg;

   // ****************************************
   // widths and table size
   // ****************************************
   localparam int PIX_W = 12;
   localparam int POS_W = 13;
   localparam int LVL_W = 8;
   localparam int SHIFT_W = 3;
   localparam int TABLE_DEPTH = 16;
   localparam int TADDR_W = 4;
   localparam int WIN_TAPS = 5;
   localparam logic [POS_W-1:0] CENTER_LAG = 13'h0003;
   localparam logic [TADDR_W-1:0] TADDR_LAST = 4'hf;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SAT = 8'h04;
   localparam logic [7:0] ADDR_MEMCTL = 8'h08;
   localparam logic [7:0] ADDR_ENT_V = 8'h0c;
   localparam logic [7:0] ADDR_ENT_H = 8'h10;
   localparam logic [7:0] ADDR_ENT_ROW = 8'h14;
   localparam logic [7:0] ADDR_ENT_UP = 8'h18;
   localparam logic [7:0] ADDR_ENT_DN = 8'h1c;
   localparam logic [7:0] ADDR_SYNC_CFG = 8'h20;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_SHIFT_LSB = 8;
   localparam int CTRL_SKIP_BIT = 7;
   localparam int CTRL_MODE_LSB = 5;
   localparam int CTRL_EN_BIT = 4;
   localparam int MEM_CLR_BIT = 4;
   localparam int MEM_RST_BIT = 2;
   localparam int MEM_RD_BIT = 1;
   localparam int MEM_WR_BIT = 0;
   localparam int SYNC_BYPASS_BIT = 15;

   // ****************************************
   // encodings
   // ****************************************
   typedef enum logic [1:0] {
      MODE_SUB_PASS = 2'h0,
      MODE_SUB_INTERP = 2'h1,
      MODE_INTERP = 2'h2,
      MODE_RSVD = 2'h3
   } corr_mode_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DATA = 1'b1
   } bus_state_t;

   typedef enum logic {
      TBL_IDLE = 1'b0,
      TBL_CLEAR = 1'b1
   } tbl_state_t;

endpackage : vline_pkg

// >>> src/vline_pixel_window.sv
// Purpose: five-pixel horizontal window for interpolation
// Assumes: shift only on valid pixels
// Notes: tap_new is the newest pixel, tap_mid the centre, tap_old the oldest
`timescale 1ns/10ps
`default_nettype none
module vline_pixel_window
   import vline_pkg::*;
(
   input wire logic hclk, // clock
   input wire logic hresetn, // async reset, active low
   input wire logic shift_en, // accept a pixel
   input wire logic [PIX_W-1:0] pix, // incoming pixel
   output logic [PIX_W-1:0] tap_new, // pixel i+2
   output logic [PIX_W-1:0] tap_mid, // pixel i
   output logic [PIX_W-1:0] tap_old // pixel i-2
);
   logic [PIX_W-1:0] taps [WIN_TAPS];
   logic [PIX_W-1:0] next_taps [WIN_TAPS];

   always_comb begin
      for (int i = 0; i < WIN_TAPS; i++) begin
         next_taps[i] = taps[i];
      end
      if (shift_en) begin
         next_taps[0] = pix;
         for (int i = 1; i < WIN_TAPS; i++) begin
            next_taps[i] = taps[i-1];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < WIN_TAPS; i++) begin
            taps[i] <= '0;
         end
      end else begin
         taps <= next_taps;
      end
   end

   assign tap_new = taps[0];
   assign tap_mid = taps[2];
   assign tap_old = taps[WIN_TAPS-1];
endmodule : vline_pixel_window
`default_nettype wire

// >>> src/vline_level_apply.sv
// Purpose: shift a defect level and subtract it from a pixel
// Assumes: shift programmed 0..4, so the shifted level fits in a pixel
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module vline_level_apply
   import vline_pkg::*;
(
   input wire logic [PIX_W-1:0] pix, // pixel value
   input wire logic [LVL_W-1:0] level, // 8-bit defect level
   input wire logic [SHIFT_W-1:0] shift, // left shift amount
   output logic [PIX_W-1:0] result // clamped difference
);
   logic [PIX_W-1:0] shifted;

   always_comb begin
      shifted = PIX_W'({{(PIX_W-LVL_W){1'b0}}, level} << shift); // [R1]
      // clamp at zero: a wrapped result would turn dark pixels white
      if (pix >= shifted) begin
         result = pix - shifted;
      end else begin
         result = '0; // [R21]
      end
   end
endmodule : vline_level_apply
`default_nettype wire

// >>> src/vline_defect_correct.sv
// Purpose: vertical line defect correction on a raw pixel stream, AHB-Lite registers
// Assumes: pixel stream and sync strobes are on hclk; one wait state per bus transfer
// Notes: corrected output lags the input by two pixels, to the window centre
//
// Behaviour
// R1: defect levels are 8 bits, shifted left by the 3-bit shift field.
// R2: software keeps the shift field at 0 to 4.
// R3: skip bit set leaves pixels above the defect start row uncorrected.
// R4: mode 0 subtract/pass saturated, 1 subtract/interpolate saturated, 2 interpolate.
// R5: saturation compares against a 12-bit unsigned threshold.
// R6: correction applies only while the enable bit is one.
// R7: a written enable takes effect at the next vertical sync.
// R8: clear strobe zeroes the whole table, then drops by itself.
// R9: restart bit makes an access use offset 0 and self-clears afterwards.
// R10: without restart, accesses walk to the next table address.
// R11: read strobe loads one entry into the five data registers, self-clears.
// R12: write strobe stores the five data registers into one entry, self-clears.
// R13: software fills all five data registers before writing.
// R14: software waits for the read strobe to drop before reading data.
// R15: software writes zeros to reserved bits.
// R16: bypass bit one applies synchronised settings at once.
// R17: an entry holds a 13-bit start row and a 13-bit column.
// R18: the third data register is the level for the start row.
// R19: fourth and fifth data registers are levels above and below.
// R20: a pixel at or above the threshold is saturating.
// R21: subtraction clamps at zero.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module vline_defect_correct
   import vline_pkg::*;
(
   input wire logic hclk, // bus and pixel clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write transfer
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic pix_valid, // pixel strobe
   input wire logic [PIX_W-1:0] pix_in, // raw pixel
   input wire logic line_start, // horizontal sync pulse
   input wire logic frame_start, // vertical sync pulse
   output logic [PIX_W-1:0] pix_out, // corrected pixel
   output logic pix_out_valid // corrected pixel strobe
);
   // ****************************************
   // state
   // ****************************************
   bus_state_t bus_state, next_bus_state;
   tbl_state_t tbl_state, next_tbl_state;
   logic [7:0] bus_addr, next_bus_addr;
   logic bus_write, next_bus_write;
   logic next_hreadyout;
   logic [31:0] next_hrdata;
   logic [SHIFT_W-1:0] level_shift_amount, next_level_shift_amount;
   logic upper_pixel_skip, next_upper_pixel_skip;
   corr_mode_t correction_method_select, next_correction_method_select;
   logic column_correction_on, next_column_correction_on;
   logic corr_active, next_corr_active;
   logic [PIX_W-1:0] saturation_threshold, next_saturation_threshold;
   logic table_clear_strobe, next_table_clear_strobe;
   logic table_address_restart, next_table_address_restart;
   logic table_read_strobe, next_table_read_strobe;
   logic table_write_strobe, next_table_write_strobe;
   logic [POS_W-1:0] entry_vertical_position, next_entry_vertical_position;
   logic [POS_W-1:0] entry_horizontal_position, next_entry_horizontal_position;
   logic [LVL_W-1:0] entry_level_at_row, next_entry_level_at_row;
   logic [LVL_W-1:0] entry_level_above, next_entry_level_above;
   logic [LVL_W-1:0] entry_level_below, next_entry_level_below;
   logic sync_latch_bypass, next_sync_latch_bypass;
   logic [TADDR_W-1:0] tbl_ptr, next_tbl_ptr;
   logic [TADDR_W-1:0] clr_cnt, next_clr_cnt;
   logic [TADDR_W-1:0] acc_addr;
   logic tbl_we, tbl_clr_we;
   logic [31:0] rd_mux;

   // defect table
   logic [POS_W-1:0] tbl_v [TABLE_DEPTH];
   logic [POS_W-1:0] tbl_h [TABLE_DEPTH];
   logic [LVL_W-1:0] tbl_row [TABLE_DEPTH];
   logic [LVL_W-1:0] tbl_up [TABLE_DEPTH];
   logic [LVL_W-1:0] tbl_dn [TABLE_DEPTH];
   logic tbl_vld [TABLE_DEPTH];

   // pixel path
   logic [POS_W-1:0] hcnt, next_hcnt;
   logic [POS_W-1:0] vcnt, next_vcnt;
   logic win_new, next_win_new;
   logic [PIX_W-1:0] next_pix_out;
   logic [PIX_W-1:0] tap_new, tap_mid, tap_old;
   logic [PIX_W-1:0] sub_res;
   logic [POS_W-1:0] ctr_col;
   logic [PIX_W:0] interp_sum;
   logic [PIX_W-1:0] interp;
   logic hit, do_corr, sat;
   logic [TADDR_W-1:0] hit_idx;
   logic [LVL_W-1:0] sel_level;

   // ****************************************
   // register file and table engine
   // ****************************************
   always_comb begin
      rd_mux = '0;
      case (bus_addr)
         ADDR_CTRL: begin
            rd_mux[CTRL_SHIFT_LSB +: SHIFT_W] = level_shift_amount;
            rd_mux[CTRL_SKIP_BIT] = upper_pixel_skip;
            rd_mux[CTRL_MODE_LSB +: 2] = correction_method_select;
            rd_mux[CTRL_EN_BIT] = column_correction_on;
         end
         ADDR_SAT: rd_mux[PIX_W-1:0] = saturation_threshold;
         ADDR_MEMCTL: begin
            rd_mux[MEM_CLR_BIT] = table_clear_strobe;
            rd_mux[MEM_RST_BIT] = table_address_restart;
            rd_mux[MEM_RD_BIT] = table_read_strobe;
            rd_mux[MEM_WR_BIT] = table_write_strobe;
         end
         ADDR_ENT_V: rd_mux[POS_W-1:0] = entry_vertical_position;
         ADDR_ENT_H: rd_mux[POS_W-1:0] = entry_horizontal_position;
         ADDR_ENT_ROW: rd_mux[LVL_W-1:0] = entry_level_at_row;
         ADDR_ENT_UP: rd_mux[LVL_W-1:0] = entry_level_above;
         ADDR_ENT_DN: rd_mux[LVL_W-1:0] = entry_level_below;
         ADDR_SYNC_CFG: rd_mux[SYNC_BYPASS_BIT] = sync_latch_bypass;
         default: rd_mux = '0;
      endcase
   end

   always_comb begin
      next_bus_state = bus_state;
      next_tbl_state = tbl_state;
      next_bus_addr = bus_addr;
      next_bus_write = bus_write;
      next_hreadyout = hreadyout;
      next_hrdata = hrdata;
      next_level_shift_amount = level_shift_amount;
      next_upper_pixel_skip = upper_pixel_skip;
      next_correction_method_select = correction_method_select;
      next_column_correction_on = column_correction_on;
      next_saturation_threshold = saturation_threshold;
      next_table_clear_strobe = table_clear_strobe;
      next_table_address_restart = table_address_restart;
      next_table_read_strobe = table_read_strobe;
      next_table_write_strobe = table_write_strobe;
      next_entry_vertical_position = entry_vertical_position;
      next_entry_horizontal_position = entry_horizontal_position;
      next_entry_level_at_row = entry_level_at_row;
      next_entry_level_above = entry_level_above;
      next_entry_level_below = entry_level_below;
      next_sync_latch_bypass = sync_latch_bypass;
      next_tbl_ptr = tbl_ptr;
      next_clr_cnt = clr_cnt;
      tbl_we = 1'b0;
      tbl_clr_we = 1'b0;
      acc_addr = table_address_restart ? '0 : tbl_ptr; // [R9] [R10]

      // enable follows the written value at vertical sync, or at once while bypass is set
      if (sync_latch_bypass || frame_start) begin
         next_corr_active = column_correction_on; // [R7] [R16]
      end else begin
         next_corr_active = corr_active;
      end

      // table engine: hardware clears come first so a bus set below wins
      case (tbl_state)
         TBL_IDLE: begin
            if (table_clear_strobe) begin
               next_tbl_state = TBL_CLEAR;
               next_clr_cnt = '0;
            end else if (table_write_strobe) begin
               tbl_we = 1'b1; // [R12]
               next_tbl_ptr = acc_addr + 1'b1; // [R10]
               next_table_write_strobe = 1'b0; // [R12]
               next_table_address_restart = 1'b0; // [R9]
            end else if (table_read_strobe) begin
               next_entry_vertical_position = tbl_v[acc_addr]; // [R11] [R17]
               next_entry_horizontal_position = tbl_h[acc_addr];
               next_entry_level_at_row = tbl_row[acc_addr];
               next_entry_level_above = tbl_up[acc_addr];
               next_entry_level_below = tbl_dn[acc_addr];
               next_tbl_ptr = acc_addr + 1'b1; // [R10]
               next_table_read_strobe = 1'b0; // [R11]
               next_table_address_restart = 1'b0; // [R9]
            end
         end
         TBL_CLEAR: begin
            tbl_clr_we = 1'b1; // [R8]
            next_clr_cnt = clr_cnt + 1'b1;
            if (clr_cnt == TADDR_LAST) begin
               next_tbl_state = TBL_IDLE;
               next_table_clear_strobe = 1'b0; // [R8]
            end
         end
         default: next_tbl_state = TBL_IDLE;
      endcase

      // one wait state lets read data come straight from a flop
      case (bus_state)
         BUS_IDLE: begin
            if (hsel && hready && htrans[1]) begin
               next_bus_addr = haddr[7:0];
               next_bus_write = hwrite;
               next_hreadyout = 1'b0;
               next_bus_state = BUS_DATA;
            end
         end
         BUS_DATA: begin
            next_hreadyout = 1'b1;
            next_bus_state = BUS_IDLE;
            if (!bus_write) begin
               next_hrdata = rd_mux;
            end else begin
               case (bus_addr)
                  ADDR_CTRL: begin
                     next_level_shift_amount = hwdata[CTRL_SHIFT_LSB +: SHIFT_W]; // [R1]
                     next_upper_pixel_skip = hwdata[CTRL_SKIP_BIT]; // [R3]
                     next_correction_method_select =
                        corr_mode_t'(hwdata[CTRL_MODE_LSB +: 2]); // [R4]
                     next_column_correction_on = hwdata[CTRL_EN_BIT]; // [R7]
                  end
                  ADDR_SAT: next_saturation_threshold = hwdata[PIX_W-1:0]; // [R5]
                  ADDR_MEMCTL: begin
                     if (hwdata[MEM_CLR_BIT]) begin
                        next_table_clear_strobe = 1'b1; // [R8]
                     end
                     if (hwdata[MEM_RD_BIT]) begin
                        next_table_read_strobe = 1'b1; // [R11]
                     end
                     if (hwdata[MEM_WR_BIT]) begin
                        next_table_write_strobe = 1'b1; // [R12]
                     end
                     next_table_address_restart = hwdata[MEM_RST_BIT]; // [R9]
                  end
                  ADDR_ENT_V: next_entry_vertical_position = hwdata[POS_W-1:0]; // [R17]
                  ADDR_ENT_H: next_entry_horizontal_position = hwdata[POS_W-1:0]; // [R17]
                  ADDR_ENT_ROW: next_entry_level_at_row = hwdata[LVL_W-1:0]; // [R18]
                  ADDR_ENT_UP: next_entry_level_above = hwdata[LVL_W-1:0]; // [R19]
                  ADDR_ENT_DN: next_entry_level_below = hwdata[LVL_W-1:0]; // [R19]
                  ADDR_SYNC_CFG: next_sync_latch_bypass = hwdata[SYNC_BYPASS_BIT]; // [R16]
                  default: next_bus_addr = bus_addr;
               endcase
            end
         end
         default: next_bus_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= BUS_IDLE;
         tbl_state <= TBL_IDLE;
         bus_addr <= '0;
         bus_write <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= '0;
         hresp <= 1'b0;
         level_shift_amount <= '0;
         upper_pixel_skip <= 1'b0;
         correction_method_select <= MODE_SUB_PASS;
         column_correction_on <= 1'b0;
         corr_active <= 1'b0;
         saturation_threshold <= '0;
         table_clear_strobe <= 1'b0;
         table_address_restart <= 1'b0;
         table_read_strobe <= 1'b0;
         table_write_strobe <= 1'b0;
         entry_vertical_position <= '0;
         entry_horizontal_position <= '0;
         entry_level_at_row <= '0;
         entry_level_above <= '0;
         entry_level_below <= '0;
         sync_latch_bypass <= 1'b0;
         tbl_ptr <= '0;
         clr_cnt <= '0;
      end else begin
         bus_state <= next_bus_state;
         tbl_state <= next_tbl_state;
         bus_addr <= next_bus_addr;
         bus_write <= next_bus_write;
         hreadyout <= next_hreadyout;
         hrdata <= next_hrdata;
         hresp <= 1'b0;
         level_shift_amount <= next_level_shift_amount;
         upper_pixel_skip <= next_upper_pixel_skip;
         correction_method_select <= next_correction_method_select;
         column_correction_on <= next_column_correction_on;
         corr_active <= next_corr_active;
         saturation_threshold <= next_saturation_threshold;
         table_clear_strobe <= next_table_clear_strobe;
         table_address_restart <= next_table_address_restart;
         table_read_strobe <= next_table_read_strobe;
         table_write_strobe <= next_table_write_strobe;
         entry_vertical_position <= next_entry_vertical_position;
         entry_horizontal_position <= next_entry_horizontal_position;
         entry_level_at_row <= next_entry_level_at_row;
         entry_level_above <= next_entry_level_above;
         entry_level_below <= next_entry_level_below;
         sync_latch_bypass <= next_sync_latch_bypass;
         tbl_ptr <= next_tbl_ptr;
         clr_cnt <= next_clr_cnt;
      end
   end

   // ****************************************
   // defect table storage
   // ****************************************
   // a valid bit per entry keeps cleared rows from matching column 0
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < TABLE_DEPTH; i++) begin
            tbl_v[i] <= '0;
            tbl_h[i] <= '0;
            tbl_row[i] <= '0;
            tbl_up[i] <= '0;
            tbl_dn[i] <= '0;
            tbl_vld[i] <= 1'b0;
         end
      end else if (tbl_clr_we) begin
         tbl_v[clr_cnt] <= '0; // [R8]
         tbl_h[clr_cnt] <= '0;
         tbl_row[clr_cnt] <= '0;
         tbl_up[clr_cnt] <= '0;
         tbl_dn[clr_cnt] <= '0;
         tbl_vld[clr_cnt] <= 1'b0;
      end else if (tbl_we) begin
         tbl_v[acc_addr] <= entry_vertical_position; // [R12] [R17]
         tbl_h[acc_addr] <= entry_horizontal_position;
         tbl_row[acc_addr] <= entry_level_at_row; // [R18]
         tbl_up[acc_addr] <= entry_level_above; // [R19]
         tbl_dn[acc_addr] <= entry_level_below;
         tbl_vld[acc_addr] <= 1'b1;
      end
   end

   // ****************************************
   // pixel path
   // ****************************************
   vline_pixel_window u_window (
      .hclk(hclk),
      .hresetn(hresetn),
      .shift_en(pix_valid),
      .pix(pix_in),
      .tap_new(tap_new),
      .tap_mid(tap_mid),
      .tap_old(tap_old)
   );

   vline_level_apply u_apply (
      .pix(tap_mid),
      .level(sel_level),
      .shift(level_shift_amount),
      .result(sub_res)
   );

   always_comb begin
      ctr_col = hcnt - CENTER_LAG;
      hit = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < TABLE_DEPTH; i++) begin
         if (!hit && tbl_vld[i] && tbl_h[i] == ctr_col) begin
            hit = 1'b1;
            hit_idx = TADDR_W'(i);
         end
      end
      if (vcnt == tbl_v[hit_idx]) begin
         sel_level = tbl_row[hit_idx]; // [R18]
      end else if (vcnt < tbl_v[hit_idx]) begin
         sel_level = tbl_up[hit_idx]; // [R19]
      end else begin
         sel_level = tbl_dn[hit_idx]; // [R19]
      end
      do_corr = corr_active && hit
         && !(upper_pixel_skip && vcnt < tbl_v[hit_idx]); // [R3] [R6]
      interp_sum = {1'b0, tap_old} + {1'b0, tap_new};
      interp = interp_sum[PIX_W:1]; // [R4]
      sat = tap_mid >= saturation_threshold; // [R5] [R20]
      next_pix_out = win_new ? tap_mid : pix_out;
      if (do_corr && win_new) begin
         case (correction_method_select) // [R4]
            MODE_SUB_PASS: next_pix_out = sat ? tap_mid : sub_res;
            MODE_SUB_INTERP: next_pix_out = sat ? interp : sub_res;
            MODE_INTERP: next_pix_out = interp;
            default: next_pix_out = tap_mid;
         endcase
      end
      next_win_new = pix_valid;
      next_hcnt = hcnt;
      next_vcnt = vcnt;
      if (frame_start) begin
         next_vcnt = '0;
         next_hcnt = '0;
      end else if (line_start) begin
         next_vcnt = vcnt + 1'b1;
         next_hcnt = '0;
      end else if (pix_valid) begin
         next_hcnt = hcnt + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hcnt <= '0;
         vcnt <= '0;
         win_new <= 1'b0;
         pix_out <= '0;
         pix_out_valid <= 1'b0;
      end else begin
         hcnt <= next_hcnt;
         vcnt <= next_vcnt;
         win_new <= next_win_new;
         pix_out <= next_pix_out;
         pix_out_valid <= win_new; // [R6]
      end
   end
endmodule : vline_defect_correct
`default_nettype wire

// >>> verif/vline_asserts.sv
// Purpose: port-level checks of bus timing and pixel stream timing
// Assumes: one slave, hready tied to hreadyout
// Notes: bound to the top module at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module vline_asserts
   import vline_pkg::*;
(
   input wire logic hclk, hresetn, hsel, hready, hreadyout, hresp, // bus
   input wire logic [1:0] htrans, // transfer type
   input wire logic [31:0] hrdata, // read data
   input wire logic pix_valid, pix_out_valid, // strobes
   input wire logic [PIX_W-1:0] pix_out // corrected pixel
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic taken = hsel && hready && htrans[1] && hreadyout;
   bus_wait_a: assert property (taken |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
   ready_low_a: assert property (!hreadyout |=> hreadyout)
      else $error("ready low too long");
   ready_idle_a: assert property (!taken && hreadyout |=> hreadyout)
      else $error("ready dropped without transfer");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
      else $error("read data moved outside a read");
   pix_lat_a: assert property (pix_valid |-> ##2 pix_out_valid)
      else $error("output pixel missing");
   pix_src_a: assert property (pix_out_valid |-> $past(pix_valid, 2))
      else $error("output pixel without input");
   pix_hold_a: assert property ($changed(pix_out) |-> pix_out_valid)
      else $error("pixel moved without strobe");
endmodule : vline_asserts
bind vline_defect_correct vline_asserts chk (.hclk, .hresetn, .hsel, .hready, .hreadyout,
   .hresp, .htrans, .hrdata, .pix_valid, .pix_out_valid, .pix_out);
`default_nettype wire

// >>> verif/vline_pix_src.sv
// Purpose: sensor-side source of sync pulses and raw pixel lines
// Assumes: driven right after a rising edge
// Notes: twelve equal pixels per line, prompt or with gaps
`timescale 1ns/10ps
`default_nettype none
module vline_pix_src
   import vline_pkg::*;
(
   input wire logic hclk, // clock
   output logic pix_valid, // pixel strobe
   output logic [PIX_W-1:0] pix_in, // raw pixel
   output logic line_start, // row pulse
   output logic frame_start // frame pulse
);
   initial {pix_valid, pix_in, line_start, frame_start} = '0;
   task automatic sync(input logic f);
      line_start <= !f;
      frame_start <= f;
      @(posedge hclk);
      {line_start, frame_start} <= 2'h0;
      @(posedge hclk);
   endtask : sync
   // idle data is inverted so a stale pixel can never pass for a fresh one
   task automatic line(input logic [PIX_W-1:0] p, input logic slow);
      sync(1'b0);
      repeat (12) begin
         pix_valid <= 1'b1;
         pix_in <= p;
         @(posedge hclk);
         if (slow) begin
            pix_valid <= 1'b0;
            pix_in <= ~p;
            @(posedge hclk);
         end
      end
      pix_valid <= 1'b0;
      pix_in <= ~p;
   endtask : line
endmodule : vline_pix_src
`default_nettype wire

// >>> verif/test_vline_defect_correct.sv
// Purpose: register, table and stream scenarios for the corrector
// Assumes: one AHB-Lite master, one slave
// Notes: lines are uniform, so only the defect column may differ
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_vline_defect_correct
   import vline_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, pix_valid, line_start, frame_start, pix_out_valid;
   logic [PIX_W-1:0] pix_in, pix_out, cur, dv;
   int n_fail = 0, compares = 0, k, nd, t;
   logic [47:0] tab [8] = '{48'h490fff300300, 48'h010fff3002f0, 48'h430300300300,
      48'h430301300200, 48'h450fff300300, 48'h470fff300300, 48'h410300300300,
      48'h410fff0f0000};
   vline_defect_correct dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .pix_valid, .pix_in, .line_start, .frame_start, .pix_out, .pix_out_valid);
   vline_pix_src src (.hclk, .pix_valid, .pix_in, .line_start, .frame_start);
   initial forever #12.5 hclk = ~hclk;
   always @(posedge hclk) if (pix_out_valid === 1'b1) begin
      if (k >= 2 && pix_out !== cur) begin nd++; dv = pix_out; end
      k++;
   end
   task automatic finish_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic wait_rdy();
      for (t = 0; t < 50; t++) begin @(posedge hclk); if (hreadyout) break; end
      if (t == 50) begin n_fail++; finish_test(); end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      {hsel, htrans} <= 3'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : bus
   task automatic poll();
      for (int i = 0; i < 40; i++) begin bus(0, ADDR_MEMCTL, 0); if (r === 0) break; end
      if (r !== 0) begin n_fail++; finish_test(); end
   endtask : poll
   task automatic run(input logic [11:0] p, e, input logic slow);
      k = 0;
      nd = 0;
      cur = p;
      src.line(p, slow);
      repeat (4) @(posedge hclk);
      `CHK(nd, int'(e !== p))
      if (e !== p) `CHK(dv, e)
   endtask : run
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int a = 0; a < 40; a += 4) begin bus(0, a[7:0], 0); `CHK(r, 32'h0) end
      $display("reset values done");
      foreach (tab[i]) begin
         bus(1, ADDR_ENT_V + 8'h4 * i[7:0], i ? 32'h10 : 32'h3);
         if (i == 4) begin bus(1, ADDR_ENT_H, 32'h1ff); bus(1, ADDR_MEMCTL, 32'h5); poll(); end
      end
      bus(1, ADDR_ENT_H, 32'h6);
      bus(1, ADDR_MEMCTL, 32'h1);
      poll();
      bus(1, ADDR_MEMCTL, 32'h6);
      poll();
      bus(0, ADDR_ENT_H, 0); `CHK(r, 32'h1ff)
      bus(1, ADDR_MEMCTL, 32'h2);
      poll();
      bus(0, ADDR_ENT_H, 0); `CHK(r, 32'h6)
      bus(0, ADDR_ENT_ROW, 0); `CHK(r, 32'h10)
      $display("table access done");
      bus(1, ADDR_CTRL, 32'h410);
      bus(0, ADDR_CTRL, 0); `CHK(r, 32'h410)
      run(12'h300, 12'h300, 1'b0);
      src.sync(1'b1);
      foreach (tab[i]) begin
         bus(1, ADDR_CTRL, tab[i][47:36]);
         bus(1, ADDR_SAT, tab[i][35:24]);
         run(tab[i][23:12], tab[i][11:0], i[0]);
      end
      $display("correction modes done");
      bus(1, ADDR_SYNC_CFG, 32'h8000);
      bus(1, ADDR_CTRL, 32'h400);
      run(12'h300, 12'h300, 1'b0);
      bus(1, ADDR_MEMCTL, 32'h10);
      poll();
      bus(1, ADDR_MEMCTL, 32'h6);
      poll();
      bus(0, ADDR_ENT_H, 0); `CHK(r, 32'h0)
      $display("clear and bypass done");
      finish_test();
   end
   initial begin
      #2000000;
      n_fail++;
      finish_test();
   end
endmodule : test_vline_defect_correct
`default_nettype wire
